// ---- src/esm_params.svh ----
/*
  constants for the eeprom serial master: timing counts and frame layout.
  assumes the including file runs at the 25 MHz system clock.
*/
`ifndef ESM_PARAMS_SVH
`define ESM_PARAMS_SVH
`define ESM_CLK_HZ 25000000
`define ESM_BIT_RATE_HZ 1000000
// half a serial bit in system cycles, rounded down so the rate is at least 1 Mbit/s
`define ESM_HALF_CYC ((`ESM_CLK_HZ / `ESM_BIT_RATE_HZ) / 2)
`define ESM_BYTE_BITS 8
`define ESM_DIR_BIT 7
`define ESM_ADDR_W 7
`endif

// ---- src/esm_pkg.sv ----
/*
  types for the eeprom serial master.
  assumes nothing of its surroundings.
*/
package esm_pkg;
  typedef enum logic [1:0] {
    ESM_IDLE,
    ESM_INSTR,
    ESM_DATA,
    ESM_DONE
  } esm_state_t;
endpackage

// ---- src/esm_clk_div.sv ----
/*
  divider that gives a one-cycle enable pulse every half serial bit.
  assumes a single system clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "esm_params.svh"
module esm_clk_div #(
  parameter int HALF_CYC = `ESM_HALF_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_run,
  output logic o_tick
);
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } esm_div_t;
  esm_div_t st_q;
  esm_div_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (!i_run) begin
      // restart so the first half bit of a frame is full length
      st_d.cnt = 8'h00;
    end else if (st_q.cnt == 8'(HALF_CYC - 1)) begin
      st_d.cnt = 8'h00;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_tick = st_q.tick;
endmodule
`default_nettype wire

// ---- src/esm_master.sv ----
/*
  serial master for the data-logging eeprom: one instruction byte then one data byte.
  assumes the request comes from logic on i_clk; the receive line is a pin and is synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none
`include "esm_params.svh"
module esm_master #(
  parameter int HALF_CYC = `ESM_HALF_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic i_req_read,
  input wire logic [6:0] i_req_addr,
  input wire logic [7:0] i_req_wdata,
  output logic o_done,
  output logic [7:0] o_rdata,
  output logic o_sclk,
  output logic o_mosi,
  input wire logic i_miso,
  output logic o_cs_n
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    esm_pkg::esm_state_t st;
    logic read;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] wdata;
    logic [2:0] bitn;
    logic sclk;
    logic cs_n;
    logic done;
    logic [7:0] rdata;
    logic [1:0] miso_s;
    // the two fields below only feed the checks
    logic [7:0] sclk_hi;
    logic [4:0] rises;
  } esm_state_regs_t;
  esm_state_regs_t s_q;
  esm_state_regs_t s_d;
  logic tick;
  logic run;

  // true while a frame is being shifted: the divider runs and the clock may toggle
  function automatic logic shifting(input esm_pkg::esm_state_t st);
    return (st == esm_pkg::ESM_INSTR) || (st == esm_pkg::ESM_DATA);
  endfunction

  esm_clk_div #(.HALF_CYC(HALF_CYC)) u_div (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_run(run),
    .o_tick(tick)
  );

  assign run = shifting(s_q.st);

  // ----------------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    // receive pin crosses in through two flops
    s_d.miso_s = {s_q.miso_s[0], i_miso};
    // length of the current high phase, read only by the half-bit check
    s_d.sclk_hi = s_q.sclk ? s_q.sclk_hi + 8'h01 : 8'h00;
    case (s_q.st)
      esm_pkg::ESM_IDLE: begin
        s_d.sclk = 1'b0;
        s_d.cs_n = 1'b1;
        if (i_req_valid) begin
          s_d.read = i_req_read;
          s_d.tx = {i_req_read, i_req_addr};
          s_d.wdata = i_req_wdata;
          s_d.bitn = 3'h0;
          s_d.rises = 5'h00;
          s_d.cs_n = 1'b0;
          s_d.st = esm_pkg::ESM_INSTR;
        end
      end
      esm_pkg::ESM_INSTR, esm_pkg::ESM_DATA: begin
        if (tick) begin
          s_d.sclk = ~s_q.sclk;
          if (!s_q.sclk) begin
            // rising edge: sample the receive line
            s_d.rx = {s_q.rx[6:0], s_q.miso_s[1]};
            s_d.rises = s_q.rises + 5'h01;
          end else begin
            s_d.bitn = s_q.bitn + 3'h1;
            s_d.tx = {s_q.tx[6:0], 1'b0};
            if (s_q.bitn == 3'h7) begin
              if (s_q.st == esm_pkg::ESM_INSTR) begin
                // write data is in the shifter before the next clock edge
                s_d.tx = s_q.read ? 8'h00 : s_q.wdata;
                s_d.st = esm_pkg::ESM_DATA;
              end else begin
                s_d.st = esm_pkg::ESM_DONE;
              end
            end
          end
        end
      end
      esm_pkg::ESM_DONE: begin
        s_d.cs_n = 1'b1;
        s_d.done = 1'b1;
        if (s_q.read) begin
          s_d.rdata = s_q.rx;
        end
        s_d.st = esm_pkg::ESM_IDLE;
      end
      default: begin
        s_d.st = esm_pkg::ESM_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= '{st: esm_pkg::ESM_IDLE, cs_n: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign o_req_ready = (s_q.st == esm_pkg::ESM_IDLE);
  assign o_sclk = s_q.sclk;
  assign o_mosi = s_q.tx[7];
  assign o_cs_n = s_q.cs_n;
  assign o_done = s_q.done;
  assign o_rdata = s_q.rdata;

  // ----------------------------------------------------------------------
  // checks: select and handshake
  // ----------------------------------------------------------------------
  sclk_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_cs_n |-> !o_sclk) else $error("serial clock active while deselected");
  cs_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    shifting(s_q.st) |-> !o_cs_n) else $error("select dropped mid frame");
  cs_take_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_req_ready && i_req_valid) |=> !o_cs_n) else $error("select not asserted");
  // select lifts exactly on the edge that ends the frame
  cs_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_cs_n) |-> o_done) else $error("select released before frame end");
  idle_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_req_ready |-> (o_cs_n && !o_sclk)) else $error("link busy while idle");
  // ready comes up with the done pulse, so the next request may land on the next edge
  done_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_done |-> (o_cs_n && o_req_ready)) else $error("select not released");
  done_pulse_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_done |=> !o_done) else $error("done longer than one cycle");
  done_source_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_done |-> $past(s_q.st == esm_pkg::ESM_DONE)) else $error("done without a frame");

  // ----------------------------------------------------------------------
  // checks: serial clock and data
  // ----------------------------------------------------------------------
  // a counter stands in for a long repetition and follows HALF_CYC in any build
  sclk_rate_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(o_sclk) |-> s_q.sclk_hi == 8'(HALF_CYC))
    else $error("serial half bit wrong length");
  tick_frame_a: assert property (@(posedge i_clk) disable iff (i_rst)
    tick |-> shifting(s_q.st)) else $error("divider ticked outside a frame");
  sclk_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !shifting(s_q.st) |=> $stable(o_sclk)) else $error("serial clock moved outside a frame");
  instr_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_req_ready && i_req_valid) |=> o_mosi == $past(i_req_read))
    else $error("direction bit not first");
  // the whole instruction, not only its first bit, must be in the shifter
  instr_word_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_req_ready && i_req_valid) |=> s_q.tx == {$past(i_req_read), $past(i_req_addr)})
    else $error("instruction byte not loaded");
  msb_shift_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ($fell(o_sclk) && !o_cs_n && s_q.bitn != 3'h0) |-> o_mosi == $past(s_q.tx[6]))
    else $error("shift order wrong");
  // the transmit line may only move on a falling serial clock once select is down
  mosi_edge_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ($changed(o_mosi) && !o_cs_n && $past(!o_cs_n)) |-> $fell(o_sclk))
    else $error("transmit bit moved off the falling edge");
  wdata_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
    shifting(s_q.st) |=> $stable(s_q.wdata)) else $error("write byte changed mid frame");
  // the data byte sits in the shifter before the first data clock rises
  data_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (s_q.st == esm_pkg::ESM_DATA && $past(s_q.st) == esm_pkg::ESM_INSTR && !s_q.read)
    |-> (s_q.tx == s_q.wdata && !o_sclk)) else $error("write byte not loaded first");
  // the receive pin arrives two flops late, so the partner holds each bit a full period
  rx_capture_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_sclk) |-> s_q.rx[0] == $past(s_q.miso_s[1]))
    else $error("receive bit not captured on the rise");
  read_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (s_q.st == esm_pkg::ESM_DONE && s_q.read) |=> o_rdata == $past(s_q.rx))
    else $error("receive byte not loaded");
  rdata_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $changed(o_rdata) |-> o_done) else $error("read byte moved outside frame end");
  frame_len_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_req_ready && i_req_valid) |=> !o_cs_n [*8]) else $error("frame too short");
  frame_bits_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (s_q.st == esm_pkg::ESM_DONE) |-> s_q.rises == 5'(2 * `ESM_BYTE_BITS))
    else $error("frame did not carry two bytes");
endmodule
`default_nettype wire

// ---- test/esm_eeprom_model.sv ----
/*
  behavioural serial eeprom, mode 0, 128 bytes.
  assumes an instruction byte then one data byte while select is low.
*/
`timescale 1ns/1ns
`default_nettype none
module esm_eeprom_model (
  input wire logic i_clk,
  input wire logic i_sclk,
  input wire logic i_mosi,
  input wire logic i_cs_n,
  output logic o_miso,
  output logic [15:0] o_frame,
  output logic [4:0] o_bits
);
  logic [7:0] mem [128];
  logic [7:0] tx;
  logic drv;
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'hA5 ^ 8'(i);
    o_miso = 1'b0;
    drv = 1'b0;
  end
  always @(negedge i_cs_n) begin
    o_bits = 5'h00;
    drv = 1'b0;
  end
  // sample on the rise, msb first
  always @(posedge i_sclk) if (!i_cs_n) begin
    o_frame = {o_frame[14:0], i_mosi};
    o_bits = o_bits + 5'h01;
    if (o_bits == 5'h10 && !o_frame[15]) mem[o_frame[14:8]] = o_frame[7:0];
  end
  // next bit goes out on the fall
  always @(negedge i_sclk) if (!i_cs_n) begin
    if (o_bits == 5'h08 && o_frame[7]) begin
      drv = 1'b1;
      tx = mem[o_frame[6:0]];
    end else tx = {tx[6:0], 1'b0};
  end
  // an undriven line toggles so a stale bit never passes for data
  always @(posedge i_clk) o_miso <= (drv && !i_cs_n) ? tx[7] : ~o_miso;
endmodule
`default_nettype wire

// ---- test/tb.sv ----
/*
  self-checking bench for the eeprom serial master.
  assumes mode 0 framing and the behavioural eeprom model.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic valid = 1'b0;
  logic rd = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [7:0] wdata = 8'h00;
  logic ready, done, sclk, mosi, miso, cs_n;
  logic [7:0] rdata;
  logic [15:0] frame;
  logic [4:0] bits;
  logic [7:0] shadow [128];
  logic [15:0] r = 16'h57FD;
  int n_mismatch = 0;
  int comparisons = 0;
  // half bit of 4 cycles gives the 320 ns serial period
  esm_master #(.HALF_CYC(4)) dut (.i_clk(clk), .i_rst(rst), .i_req_valid(valid),
    .o_req_ready(ready), .i_req_read(rd), .i_req_addr(addr), .i_req_wdata(wdata),
    .o_done(done), .o_rdata(rdata), .o_sclk(sclk), .o_mosi(mosi), .i_miso(miso),
    .o_cs_n(cs_n));
  esm_eeprom_model eeprom (.i_clk(clk), .i_sclk(sclk), .i_mosi(mosi), .i_cs_n(cs_n),
    .o_miso(miso), .o_frame(frame), .o_bits(bits));
  initial forever #20 clk = ~clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // what the memory should see on the link: instruction, then the byte sent
  function automatic logic [15:0] exp_frame(input logic r_d, input logic [6:0] a,
    input logic [7:0] wd);
    return {r_d, a, r_d ? 8'h00 : wd};
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic do_op(input logic r_d, input logic [6:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    rd = r_d;
    addr = a;
    wdata = wd;
    valid = 1'b1;
    while (ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1 valid = 1'b0;
    while (done !== 1'b1 && n < 500) begin
      @(posedge clk);
      #1 n++;
    end
    chk("done", 16'h0001, {15'h0000, done});
    chk("bits", 16'h0010, {11'h000, bits});
    chk("frame", exp_frame(r_d, a, wd), frame);
    if (r_d) chk("rdata", {8'h00, shadow[a]}, {8'h00, rdata});
    else shadow[a] = wd;
  endtask
  always @(posedge sclk) chk("select", 16'h0000, {15'h0000, cs_n});
  initial begin
    for (int i = 0; i < 128; i++) shadow[i] = 8'hA5 ^ 8'(i);
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    chk("idle", 16'h0005, {13'h0000, cs_n, sclk, ready});
    do_op(1'b1, 7'h7F, 8'h00);
    do_op(1'b0, 7'h00, 8'hFF);
    do_op(1'b1, 7'h00, 8'h00);
    do_op(1'b0, 7'h7F, 8'h00);
    do_op(1'b1, 7'h7F, 8'h00);
    repeat (40) begin
      r = lfsr(r);
      do_op(r[0], r[7:1], r[15:8]);
    end
    end_of_test();
  end
  // about 45 frames of 131 cycles; allow three times that
  initial begin
    #(20000 * 40);
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire
